// *** rtl/maint_channel.sv ***
module maint_channel (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire mchan_pkg::reg_req_t bus,
    output logic [mchan_pkg::DATA_W-1:0] rdata,
    // Deframer side
    input wire mchan_pkg::rx_frame_t rx,
    // Framer and system timing
    input wire logic eoc_tx_boundary,
    input wire logic sf_tx_boundary,
    input wire logic pcm_frame_sync,
    input wire logic nt_mode,
    input wire logic activation_attempt,
    // Framer side
    output logic [mchan_pkg::EOC_W-1:0] eoc_tx_word,
    output logic [mchan_pkg::M_W-1:0] m4_tx_byte,
    output logic [mchan_pkg::M_W-1:0] m56_tx_byte,
    // Events
    output logic eoc_irq,
    output logic m4_irq,
    output logic m5_m6_irq,
    output logic eoc_cmd_valid,
    output logic [mchan_pkg::EOC_W-1:0] eoc_cmd,
    // Line state
    output logic data_transparent,
    output logic deact_request,
    output logic warm_start
);
    localparam int DW = mchan_pkg::DATA_W;
    localparam int EW = mchan_pkg::EOC_W;
    localparam int MW = mchan_pkg::M_W;
    localparam int HW = mchan_pkg::EOC_HI_W;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic mchan_pkg::filt_mode_t m_mode(
        input logic [1:0] ctrl
    );
        mchan_pkg::filt_mode_t m;
        m = mchan_pkg::FILT_EVERY;
        unique case (ctrl)
            mchan_pkg::CTRL_VERIFY: m = mchan_pkg::FILT_DUAL;
            mchan_pkg::CTRL_DUAL: m = mchan_pkg::FILT_DUAL;
            mchan_pkg::CTRL_DELTA: m = mchan_pkg::FILT_DELTA;
            mchan_pkg::CTRL_EVERY: m = mchan_pkg::FILT_EVERY;
        endcase
        return m;
    endfunction : m_mode

    function automatic logic hit_addr(
        input logic [mchan_pkg::ADDR_W-1:0] a,
        input logic [mchan_pkg::ADDR_W-1:0] want,
        input logic strobe
    );
        return strobe && (a == want);
    endfunction : hit_addr

    // ************************************************************
    // Host registers
    // ************************************************************
    logic [DW-1:0] mode_ctrl_r;
    logic [DW-1:0] link_ctrl_r;
    logic [DW-1:0] irq_en_r;
    logic [DW-1:0] m4_opt_r;
    logic [HW-1:0] eoc_hi_r;
    logic [1:0] eoc_ctrl;
    logic [1:0] m4_ctrl;
    logic [1:0] m56_ctrl;
    logic m4_trinal;
    logic eoc_auto;

    assign eoc_ctrl = mode_ctrl_r[mchan_pkg::EOC_CTRL_LSB +: 2];
    assign m4_ctrl = mode_ctrl_r[mchan_pkg::M4_CTRL_LSB +: 2];
    assign m56_ctrl = mode_ctrl_r[mchan_pkg::M56_CTRL_LSB +: 2];
    assign m4_trinal = m4_opt_r[mchan_pkg::OPT_M4_TRINAL];
    assign eoc_auto = nt_mode && (eoc_ctrl == mchan_pkg::EOC_AUTO);

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_ctrl_r <= mchan_pkg::MODE_CTRL_RST;
            link_ctrl_r <= '0;
            irq_en_r <= '0;
            m4_opt_r <= '0;
            eoc_hi_r <= '0;
        end else begin
            if (hit_addr(bus.addr, mchan_pkg::A_MODE_CTRL, bus.wr)) begin
                mode_ctrl_r <= bus.wdata;
            end
            if (hit_addr(bus.addr, mchan_pkg::A_LINK_CTRL, bus.wr)) begin
                link_ctrl_r <= bus.wdata;
            end
            if (hit_addr(bus.addr, mchan_pkg::A_IRQ_EN, bus.wr)) begin
                irq_en_r <= bus.wdata;
            end
            if (hit_addr(bus.addr, mchan_pkg::A_M4_OPT, bus.wr)) begin
                m4_opt_r <= bus.wdata;
            end
            if (hit_addr(bus.addr, mchan_pkg::A_EOC_HI, bus.wr)) begin
                eoc_hi_r <= bus.wdata[HW-1:0];
            end
        end
    end

    // ************************************************************
    // Receive filters
    // ************************************************************
    logic m_frame;
    logic e_frame;
    logic lost;
    logic [EW-1:0] eoc_rx;
    logic eoc_upd;
    logic [MW-1:0] m4_mode_held;
    logic [MW-1:0] m4_tri_held;
    logic m4_mode_upd;
    logic m4_tri_upd;
    logic [MW-1:0] m4_mode_mask;
    logic [MW-1:0] m4_rx;
    logic m4_upd;
    logic [MW-1:0] m56_rx;
    logic m56_upd;
    mchan_pkg::filt_mode_t eoc_mode;

    // Frames outside sync never reach a filter
    assign m_frame = rx.sync && rx.sf_end;
    assign e_frame = rx.sync && rx.eoc_valid;
    assign lost = !rx.sync;
    assign eoc_mode = (eoc_ctrl == mchan_pkg::CTRL_EVERY)
        ? mchan_pkg::FILT_EVERY : mchan_pkg::FILT_TRINAL;

    // M1-M3 as one word, M4-M6 as overhead bytes
    match_filter #(.W(EW), .RESET_VAL('0)) eoc_filt (
        .clk(clk),
        .reset(reset),
        .restart(lost),
        .frame_valid(e_frame),
        .rx_data(rx.eoc),
        .mask({EW{1'b1}}),
        .mode(eoc_mode),
        .held(eoc_rx),
        .upd(eoc_upd)
    );

    assign m4_mode_mask = m4_trinal ? ~mchan_pkg::M4_TRINAL_MASK
                                    : {MW{1'b1}};

    match_filter #(.W(MW), .RESET_VAL('1)) m4_filt (
        .clk(clk),
        .reset(reset),
        .restart(lost),
        .frame_valid(m_frame),
        .rx_data(rx.m4),
        .mask(m4_mode_mask),
        .mode(m_mode(m4_ctrl)),
        .held(m4_mode_held),
        .upd(m4_mode_upd)
    );

    match_filter #(.W(MW), .RESET_VAL('1)) m4_tri_filt (
        .clk(clk),
        .reset(reset),
        .restart(lost),
        .frame_valid(m_frame && m4_trinal),
        .rx_data(rx.m4),
        .mask(mchan_pkg::M4_TRINAL_MASK),
        .mode(mchan_pkg::FILT_TRINAL),
        .held(m4_tri_held),
        .upd(m4_tri_upd)
    );

    // Trinal positions come from their own checker, the rest by mode
    assign m4_rx = m4_trinal
        ? ((m4_tri_held & mchan_pkg::M4_TRINAL_MASK)
           | (m4_mode_held & ~mchan_pkg::M4_TRINAL_MASK))
        : m4_mode_held;
    assign m4_upd = m4_mode_upd || (m4_trinal && m4_tri_upd);

    // Same modes as M4, never verified
    match_filter #(.W(MW), .RESET_VAL('1)) m56_filt (
        .clk(clk),
        .reset(reset),
        .restart(lost),
        .frame_valid(m_frame),
        .rx_data(rx.m56),
        .mask({MW{1'b1}}),
        .mode(m_mode(m56_ctrl)),
        .held(m56_rx),
        .upd(m56_upd)
    );

    // ************************************************************
    // Verification and automatic eoc
    // ************************************************************
    logic v_act_r;
    logic v_dea_r;

    // Act verified in either role, dea only at the network end;
    // dea is active low on the line, so a 0 verifies it
    always_ff @(posedge clk) begin
        if (reset) begin
            v_act_r <= 1'b0;
            v_dea_r <= 1'b0;
        end else if (m4_ctrl != mchan_pkg::CTRL_VERIFY) begin
            v_act_r <= 1'b0;
            v_dea_r <= 1'b0;
        end else if (m4_upd) begin
            v_act_r <= m4_rx[mchan_pkg::M4_ACT];
            v_dea_r <= nt_mode && !m4_rx[mchan_pkg::M4_DEA];
        end
    end

    // The decoded message is acted on only after a trinal update
    always_ff @(posedge clk) begin
        if (reset) begin
            eoc_cmd_valid <= 1'b0;
            eoc_cmd <= '0;
        end else begin
            eoc_cmd_valid <= eoc_upd && eoc_auto;
            if (eoc_upd && eoc_auto) begin
                eoc_cmd <= eoc_rx;
            end
        end
    end

    // ************************************************************
    // Transmit words
    // ************************************************************
    logic eoc_host_load;
    logic [EW-1:0] eoc_host_word;
    logic [MW-1:0] m4_staged;
    logic [MW-1:0] m56_staged;

    // In automatic mode the processor echoes the message and host
    // writes to the eoc word are held back from the framer
    assign eoc_host_load = eoc_auto ? eoc_cmd_valid
        : hit_addr(bus.addr, mchan_pkg::A_EOC_LO, bus.wr);
    assign eoc_host_word = eoc_auto ? eoc_cmd
        : {eoc_hi_r, bus.wdata};

    tx_word_stage #(.W(EW), .RESET_VAL(mchan_pkg::EOC_TX_RST)) eoc_tx (
        .clk(clk),
        .reset(reset),
        .load(eoc_host_load),
        .wdata(eoc_host_word),
        .boundary(eoc_tx_boundary),
        .staged(),
        .word(eoc_tx_word)
    );

    tx_word_stage #(.W(MW), .RESET_VAL(mchan_pkg::M4_TX_RST)) m4_tx (
        .clk(clk),
        .reset(reset),
        .load(hit_addr(bus.addr, mchan_pkg::A_M4_TX, bus.wr)),
        .wdata(bus.wdata),
        .boundary(sf_tx_boundary),
        .staged(m4_staged),
        .word(m4_tx_byte)
    );

    tx_word_stage #(.W(MW), .RESET_VAL(mchan_pkg::M56_TX_RST)) m56_tx (
        .clk(clk),
        .reset(reset),
        .load(hit_addr(bus.addr, mchan_pkg::A_M56_TX, bus.wr)),
        .wdata(bus.wdata),
        .boundary(sf_tx_boundary),
        .staged(m56_staged),
        .word(m56_tx_byte)
    );

    // ************************************************************
    // Update interrupts
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            eoc_irq <= 1'b0;
            m4_irq <= 1'b0;
            m5_m6_irq <= 1'b0;
        end else begin
            eoc_irq <= eoc_upd && irq_en_r[mchan_pkg::IE_EOC];
            m4_irq <= m4_upd && irq_en_r[mchan_pkg::IE_M4];
            m5_m6_irq <= m56_upd && irq_en_r[mchan_pkg::IE_M56];
        end
    end

    // ************************************************************
    // Transparency and deactivation
    // ************************************************************
    logic cust_en;
    logic deact_cause;
    mchan_pkg::link_state_t ls_r;

    assign cust_en = link_ctrl_r[mchan_pkg::CT_CUST_EN];

    // Taken on the pcm frame, so a host enable does not wait for
    // the next superframe
    always_ff @(posedge clk) begin
        if (reset) begin
            data_transparent <= 1'b0;
        end else if (pcm_frame_sync) begin
            data_transparent <= v_act_r || cust_en;
        end
    end

    assign deact_cause = nt_mode
        && (v_dea_r || link_ctrl_r[mchan_pkg::CT_DEACT_REQ]);

    always_ff @(posedge clk) begin
        if (reset) begin
            ls_r <= mchan_pkg::LS_ACTIVE;
        end else begin
            unique case (ls_r)
                mchan_pkg::LS_ACTIVE: begin
                    if (deact_cause) begin
                        ls_r <= mchan_pkg::LS_DEACT;
                    end
                end
                mchan_pkg::LS_DEACT: begin
                    if (lost) begin
                        ls_r <= mchan_pkg::LS_WARM;
                    end
                end
                mchan_pkg::LS_WARM: begin
                    if (activation_attempt) begin
                        ls_r <= mchan_pkg::LS_ACTIVE;
                    end
                end
                default: begin
                    ls_r <= mchan_pkg::LS_ACTIVE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            deact_request <= 1'b0;
            warm_start <= 1'b0;
        end else begin
            deact_request <= (ls_r == mchan_pkg::LS_DEACT)
                || (ls_r == mchan_pkg::LS_ACTIVE && deact_cause);
            warm_start <= (ls_r == mchan_pkg::LS_WARM)
                || (ls_r == mchan_pkg::LS_DEACT);
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    logic [DW-1:0] rd_mux;
    logic [DW-1:0] status;
    logic [DW-1:0] verified;

    assign status = {{(DW-1){1'b0}}, rx.sync} << mchan_pkg::ST_SYNC;
    assign verified = ({{(DW-1){1'b0}}, v_act_r} << mchan_pkg::VS_ACT)
        | ({{(DW-1){1'b0}}, v_dea_r} << mchan_pkg::VS_DEA);

    always_comb begin
        rd_mux = '0;
        unique case (bus.addr)
            mchan_pkg::A_MODE_CTRL: rd_mux = mode_ctrl_r;
            mchan_pkg::A_M4_RX: rd_mux = m4_rx;
            mchan_pkg::A_M4_TX: rd_mux = m4_staged;
            mchan_pkg::A_M56_RX: rd_mux = m56_rx;
            mchan_pkg::A_VERIFIED: rd_mux = verified;
            mchan_pkg::A_EOC_HI: rd_mux = {{(DW-HW){1'b0}}, eoc_rx[EW-1:DW]};
            mchan_pkg::A_EOC_LO: rd_mux = eoc_rx[DW-1:0];
            mchan_pkg::A_LINK_STATUS: rd_mux = status;
            mchan_pkg::A_LINK_CTRL: rd_mux = link_ctrl_r;
            mchan_pkg::A_IRQ_EN: rd_mux = irq_en_r;
            mchan_pkg::A_M4_OPT: rd_mux = m4_opt_r;
            mchan_pkg::A_M56_TX: rd_mux = m56_staged;
            default: rd_mux = '0;
        endcase
    end

    // Read data stand the cycle after each cycle that rd is high; zero otherwise
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= '0;
        end else if (bus.rd) begin
            rdata <= rd_mux;
        end else begin
            rdata <= '0;
        end
    end

endmodule : maint_channel

// *** rtl/mchan_pkg.sv ***
package mchan_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int EOC_W = 12;
    localparam int M_W = 8;
    localparam int EOC_HI_W = EOC_W - DATA_W;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [ADDR_W-1:0] A_MODE_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] A_M4_RX = 4'h1;
    localparam logic [ADDR_W-1:0] A_M4_TX = 4'h2;
    localparam logic [ADDR_W-1:0] A_M56_RX = 4'h3;
    localparam logic [ADDR_W-1:0] A_VERIFIED = 4'h4;
    localparam logic [ADDR_W-1:0] A_EOC_HI = 4'h5;
    localparam logic [ADDR_W-1:0] A_EOC_LO = 4'h6;
    localparam logic [ADDR_W-1:0] A_LINK_STATUS = 4'h7;
    localparam logic [ADDR_W-1:0] A_LINK_CTRL = 4'h8;
    localparam logic [ADDR_W-1:0] A_IRQ_EN = 4'h9;
    localparam logic [ADDR_W-1:0] A_M4_OPT = 4'ha;
    localparam logic [ADDR_W-1:0] A_M56_TX = 4'hb;

    // ************************************************************
    // Fields
    // ************************************************************
    localparam int EOC_CTRL_LSB = 6;
    localparam int M4_CTRL_LSB = 4;
    localparam int M56_CTRL_LSB = 2;
    localparam int ST_SYNC = 1;
    localparam int CT_CUST_EN = 0;
    localparam int CT_DEACT_REQ = 2;
    localparam int IE_M56 = 0;
    localparam int IE_M4 = 1;
    localparam int IE_EOC = 2;
    localparam int OPT_M4_TRINAL = 0;
    localparam int VS_ACT = 2;
    localparam int VS_DEA = 1;
    localparam int M4_ACT = 7;
    localparam int M4_DEA = 6;
    localparam logic [M_W-1:0] M4_TRINAL_MASK = 8'hf0;

    localparam logic [1:0] CTRL_VERIFY = 2'h0;
    localparam logic [1:0] CTRL_DUAL = 2'h1;
    localparam logic [1:0] CTRL_DELTA = 2'h2;
    localparam logic [1:0] CTRL_EVERY = 2'h3;
    localparam logic [1:0] EOC_AUTO = 2'h1;
    localparam logic [1:0] HIST_FULL = 2'h2;

    localparam logic [DATA_W-1:0] MODE_CTRL_RST = 8'h00;
    localparam logic [M_W-1:0] M56_TX_RST = 8'hff;
    localparam logic [M_W-1:0] M4_TX_RST = 8'hff;
    localparam logic [EOC_W-1:0] EOC_TX_RST = 12'hfff;

    typedef enum logic [1:0] {
        FILT_DUAL = 2'h0,
        FILT_DELTA = 2'h1,
        FILT_EVERY = 2'h2,
        FILT_TRINAL = 2'h3
    } filt_mode_t;

    typedef enum logic [2:0] {
        LS_ACTIVE = 3'b001,
        LS_DEACT = 3'b010,
        LS_WARM = 3'b100
    } link_state_t;

    typedef struct packed {
        logic sync;
        logic eoc_valid;
        logic [EOC_W-1:0] eoc;
        logic sf_end;
        logic [M_W-1:0] m4;
        logic [M_W-1:0] m56;
    } rx_frame_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : mchan_pkg

// *** rtl/match_filter.sv ***
module match_filter #(
    parameter int W = 8,
    parameter logic [W-1:0] RESET_VAL = '1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Received frames
    input wire logic restart,
    input wire logic frame_valid,
    input wire logic [W-1:0] rx_data,
    input wire logic [W-1:0] mask,
    input wire mchan_pkg::filt_mode_t mode,
    // Filtered register
    output logic [W-1:0] held,
    output logic upd
);
    logic [W-1:0] prev1_r;
    logic [W-1:0] prev2_r;
    logic [W-1:0] held_r;
    logic [W-1:0] take;
    logic [1:0] depth_r;
    logic hit;

    always_comb begin
        take = mask;
        hit = 1'b0;
        unique case (mode)
            mchan_pkg::FILT_DUAL: begin
                take = mask & ~(rx_data ^ prev1_r) & (rx_data ^ held_r);
                hit = (depth_r != 2'h0) && (take != '0);
            end
            mchan_pkg::FILT_DELTA: begin
                hit = (depth_r != 2'h0)
                    && (((rx_data ^ prev1_r) & mask) != '0);
            end
            mchan_pkg::FILT_EVERY: begin
                hit = 1'b1;
            end
            mchan_pkg::FILT_TRINAL: begin
                hit = (depth_r == mchan_pkg::HIST_FULL)
                    && ((((rx_data ^ prev1_r) | (rx_data ^ prev2_r))
                        & mask) == '0)
                    && (((rx_data ^ held_r) & mask) != '0);
            end
        endcase
    end

    // Stale frames from before a sync loss never count
    always_ff @(posedge clk) begin
        if (reset || restart) begin
            depth_r <= 2'h0;
            prev1_r <= '0;
            prev2_r <= '0;
        end else if (frame_valid) begin
            prev1_r <= rx_data;
            prev2_r <= prev1_r;
            if (depth_r != mchan_pkg::HIST_FULL) begin
                depth_r <= depth_r + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            held_r <= RESET_VAL;
            upd <= 1'b0;
        end else begin
            upd <= frame_valid && hit;
            if (frame_valid && hit) begin
                held_r <= (held_r & ~take) | (rx_data & take);
            end
        end
    end

    assign held = held_r;

endmodule : match_filter

// *** rtl/tx_word_stage.sv ***
module tx_word_stage #(
    parameter int W = 8,
    parameter logic [W-1:0] RESET_VAL = '1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Host side
    input wire logic load,
    input wire logic [W-1:0] wdata,
    // Framer side
    input wire logic boundary,
    output logic [W-1:0] staged,
    output logic [W-1:0] word
);
    logic [W-1:0] stage_r;
    logic [W-1:0] word_r;
    logic pend_r;

    // A write landing on the boundary waits for the next one, so the
    // framer never sees a half-changed frame
    always_ff @(posedge clk) begin
        if (reset) begin
            stage_r <= RESET_VAL;
            pend_r <= 1'b0;
        end else if (load) begin
            stage_r <= wdata;
            pend_r <= 1'b1;
        end else if (boundary) begin
            pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            word_r <= RESET_VAL;
        end else if (boundary && pend_r && !load) begin
            word_r <= stage_r;
        end
    end

    assign staged = stage_r;
    assign word = word_r;

endmodule : tx_word_stage

// *** test/maint_channel_assertions.sv ***
module maint_channel_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Inputs
    input wire mchan_pkg::rx_frame_t rx,
    input wire logic eoc_tx_boundary,
    input wire logic sf_tx_boundary,
    input wire logic pcm_frame_sync,
    input wire logic nt_mode,
    // Outputs
    input wire logic [mchan_pkg::EOC_W-1:0] eoc_tx_word,
    input wire logic [mchan_pkg::M_W-1:0] m4_tx_byte,
    input wire logic eoc_irq,
    input wire logic m4_irq,
    input wire logic m5_m6_irq,
    input wire logic data_transparent,
    input wire logic deact_request
);
    timeunit 1ns;
    timeprecision 1ns;
    // ******
    // Checks
    // ******
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    a_sync_gate: assert property (
        rx.sf_end && !rx.sync |-> ##2 !m4_irq) else $error("m4 irq no sync");
    a_m4_irq_cause: assert property (
        m4_irq |-> $past(rx.sf_end, 2) && $past(rx.sync, 2))
        else $error("m4 irq without frame");
    a_m56_irq_cause: assert property (
        m5_m6_irq |-> $past(rx.sf_end, 2) && $past(rx.sync, 2))
        else $error("m5 m6 irq without frame");
    a_eoc_irq_cause: assert property (
        eoc_irq |-> $past(rx.eoc_valid, 2) && $past(rx.sync, 2))
        else $error("eoc irq without frame");
    // Reset itself reloads the words, so the edge after it is exempt
    a_eoc_tx_load: assert property (
        $changed(eoc_tx_word) && !$past(reset) |-> $past(eoc_tx_boundary))
        else $error("eoc tx word off boundary");
    a_m4_tx_load: assert property (
        $changed(m4_tx_byte) && !$past(reset) |-> $past(sf_tx_boundary))
        else $error("m4 tx byte off boundary");
    a_transp_pcm: assert property (
        $changed(data_transparent) && !$past(reset)
        |-> $past(pcm_frame_sync)) else $error("transparency off pcm frame");
    a_deact_nt: assert property (
        $rose(deact_request) |-> nt_mode) else $error("deact outside nt");
    c_m4: cover property (m4_irq);
    c_eoc: cover property (eoc_irq);
    c_transp: cover property ($rose(data_transparent));
endmodule : maint_channel_checker

bind maint_channel maint_channel_checker u_chk (.*);

// *** test/far_end_model.sv ***
module far_end_model (
    // Clock
    input wire logic clk,
    // Deframer side
    output mchan_pkg::rx_frame_t rx
);
    timeunit 1ns;
    timeprecision 1ns;
    // **************
    // Frame delivery
    // **************
    initial rx = '0;
    task automatic set_sync(input logic s);
        @(posedge clk);
        rx.sync <= s;
    endtask : set_sync
    // Mid and end eoc frames; idle data is inverted so stale values fail
    task automatic send_sf(input logic [7:0] m4, m56, input logic [11:0] e);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            rx.eoc_valid <= 1'b1;
            rx.sf_end <= i[0];
            rx.eoc <= e;
            rx.m4 <= m4;
            rx.m56 <= m56;
            @(posedge clk);
            rx.eoc_valid <= 1'b0;
            rx.sf_end <= 1'b0;
            rx.eoc <= ~e;
            rx.m4 <= ~m4;
            rx.m56 <= ~m56;
        end
    endtask : send_sf
endmodule : far_end_model

// *** test/tb_maint_channel.sv ***
module tb_maint_channel;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] mode;
        logic [7:0] f1, f2, reg_e;
        logic [3:0] irqs, eocs;
    } row_t;
    logic clk, reset, etb, stb, pcm, nt, eoc_irq, m4_irq, m5_m6_irq, dt, dr;
    mchan_pkg::reg_req_t bus;
    mchan_pkg::rx_frame_t rx;
    logic [7:0] rdata, m4_tx, m56_tx;
    logic [11:0] eoc_tx;
    logic att, ecv, ws;
    logic [11:0] ecmd;
    int fails, n_tests, n_m4, n_m56, n_eoc, n_cmd;
    row_t rows [4] = '{'{2'h0, 8'h12, 8'h12, 8'h12, 4'h1, 4'h1},
        '{2'h1, 8'h12, 8'h12, 8'h12, 4'h1, 4'h1},
        '{2'h2, 8'h12, 8'h34, 8'h34, 4'h1, 4'h1},
        '{2'h3, 8'h12, 8'h12, 8'h12, 4'h2, 4'h4}};
    maint_channel u_dut (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
        .rx(rx), .eoc_tx_boundary(etb), .sf_tx_boundary(stb),
        .pcm_frame_sync(pcm), .nt_mode(nt), .activation_attempt(att),
        .eoc_tx_word(eoc_tx), .m4_tx_byte(m4_tx), .m56_tx_byte(m56_tx),
        .eoc_irq(eoc_irq), .m4_irq(m4_irq), .m5_m6_irq(m5_m6_irq),
        .eoc_cmd_valid(ecv), .eoc_cmd(ecmd), .data_transparent(dt),
        .deact_request(dr), .warm_start(ws));
    far_end_model u_far (.clk(clk), .rx(rx));
    // *******
    // Helpers
    // *******
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (m4_irq === 1'b1) n_m4++;
        if (m5_m6_irq === 1'b1) n_m56++;
        if (eoc_irq === 1'b1) n_eoc++;
        if (ecv === 1'b1) n_cmd++;
    end
    task automatic chk(input string nm, input logic [11:0] e, g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e, string nm);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        chk(nm, {4'h0, e}, {4'h0, rdata});
    endtask : rd
    task automatic do_reset(input int n);
        @(posedge clk);
        reset <= 1'b1;
        repeat (n) @(posedge clk);
        reset <= 1'b0;
        wr(mchan_pkg::A_IRQ_EN, 8'h07);
    endtask : do_reset
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    // *****
    // Tests
    // *****
    initial begin
        {etb, stb, pcm, nt, att, fails, n_tests} = '0;
        reset = 1'b1;
        bus = '0;
        do_reset(16);
        u_far.set_sync(1'b1);
        foreach (rows[i]) begin
            do_reset(2);
            wr(mchan_pkg::A_MODE_CTRL, {{3{rows[i].mode}}, 2'h0});
            {n_m4, n_m56, n_eoc} = '0;
            u_far.send_sf(rows[i].f1, rows[i].f1, 12'h5a3);
            u_far.send_sf(rows[i].f2, rows[i].f2, 12'h5a3);
            repeat (3) @(posedge clk);
            rd(mchan_pkg::A_M4_RX, rows[i].reg_e, "m4 rx");
            rd(mchan_pkg::A_M56_RX, rows[i].reg_e, "m56 rx");
            rd(mchan_pkg::A_EOC_LO, 8'ha3, "eoc rx");
            chk("m4 irqs", {8'h0, rows[i].irqs}, n_m4[11:0]);
            chk("m56 irqs", {8'h0, rows[i].irqs}, n_m56[11:0]);
            chk("eoc irqs", {8'h0, rows[i].eocs}, n_eoc[11:0]);
        end
        // A frame during a sync loss must not count, nor a frame before it toward a dual match
        do_reset(2);
        wr(mchan_pkg::A_MODE_CTRL, 8'h1c);
        {n_m4, n_m56} = '0;
        u_far.send_sf(8'h56, 8'h56, 12'h000);
        u_far.set_sync(1'b0);
        u_far.send_sf(8'h56, 8'h78, 12'h000);
        u_far.set_sync(1'b1);
        u_far.send_sf(8'h56, 8'h56, 12'h000);
        repeat (3) @(posedge clk);
        rd(mchan_pkg::A_M4_RX, 8'hff, "m4 after loss");
        chk("m4 irqs loss", 12'h0, n_m4[11:0]);
        chk("m56 irqs loss", 12'h2, n_m56[11:0]);
        rd(4'hf, 8'h00, "unmapped");
        wr(mchan_pkg::A_M4_TX, 8'h81);
        wr(mchan_pkg::A_LINK_CTRL, 8'h01);
        wr(mchan_pkg::A_EOC_HI, 8'h0c);
        wr(mchan_pkg::A_EOC_LO, 8'h3d);
        wr(mchan_pkg::A_M56_TX, 8'h3c);
        @(negedge clk);
        chk("transp early", 12'h0, {11'h0, dt});
        chk("eoc tx held", 12'hfff, eoc_tx);
        @(posedge clk);
        {etb, stb, pcm, nt} <= 4'hf;
        @(posedge clk);
        {etb, stb, pcm} <= 3'h0;
        @(negedge clk);
        chk("transp", 12'h1, {11'h0, dt});
        chk("eoc tx", 12'hc3d, eoc_tx);
        chk("m4 tx", 12'h081, {4'h0, m4_tx});
        chk("m56 tx", 12'h03c, {4'h0, m56_tx});
        wr(mchan_pkg::A_LINK_CTRL, 8'h05);
        repeat (3) @(posedge clk);
        chk("deact", 12'h1, {11'h0, dr});
        // Trinal act/dea in verify mode, automatic eoc at the network end
        do_reset(2);
        wr(mchan_pkg::A_MODE_CTRL, 8'h40);
        wr(mchan_pkg::A_M4_OPT, 8'h01);
        n_cmd = 0;
        repeat (2) u_far.send_sf(8'h85, 8'hff, 12'h2c7);
        repeat (3) @(posedge clk);
        rd(mchan_pkg::A_M4_RX, 8'hf5, "m4 dual part");
        chk("eoc cmd", 12'h2c7, ecmd);
        chk("eoc cmds", 12'h1, n_cmd[11:0]);
        u_far.send_sf(8'h85, 8'hff, 12'h2c7);
        repeat (3) @(posedge clk);
        rd(mchan_pkg::A_M4_RX, 8'h85, "m4 trinal");
        rd(mchan_pkg::A_VERIFIED, 8'h06, "verified");
        @(posedge clk);
        pcm <= 1'b1;
        @(posedge clk);
        pcm <= 1'b0;
        @(negedge clk);
        chk("transp act", 12'h1, {11'h0, dt});
        chk("deact dea", 12'h1, {11'h0, dr});
        u_far.set_sync(1'b0);
        wr(mchan_pkg::A_MODE_CTRL, 8'h50);
        chk("warm", 12'h1, {11'h0, ws});
        att <= 1'b1;
        @(posedge clk);
        att <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("warm left", 12'h0, {11'h0, ws});
        chk("deact left", 12'h0, {11'h0, dr});
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        wrap_up();
    end
endmodule : tb_maint_channel
